// ---- src/phy_mgmt_pkg.sv ----
// Constants, field layouts and carriers for the PHY management register bank
package phy_mgmt_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [4:0] REG_CONTROL   = 5'h00;
    localparam logic [4:0] REG_STATUS    = 5'h01;
    localparam logic [4:0] REG_ID_HI     = 5'h02;
    localparam logic [4:0] REG_ID_LO     = 5'h03;
    localparam logic [4:0] REG_ADVERT    = 5'h04;
    localparam logic [4:0] REG_PARTNER   = 5'h05;
    localparam logic [4:0] REG_CONFIG1   = 5'h10;
    localparam logic [4:0] REG_CONFIG2   = 5'h11;
    localparam logic [4:0] REG_STAT_OUT  = 5'h12;
    localparam logic [4:0] REG_MASK      = 5'h13;

    // ------------------------------------------------------------------
    // Control field positions and reset value
    // ------------------------------------------------------------------
    localparam int CTL_SOFT_RESET   = 15;
    localparam int CTL_LOOP_BACK    = 14;
    localparam int CTL_SPEED        = 13;
    localparam int CTL_AUTONEG_EN   = 12;
    localparam int CTL_POWER_DOWN   = 11;
    localparam int CTL_ISOLATE      = 10;
    localparam int CTL_AUTONEG_RST  = 9;
    localparam int CTL_DUPLEX       = 8;
    localparam int CTL_COL_TEST     = 7;
    localparam logic [15:0] CONTROL_RESET = 16'h3400;

    // ------------------------------------------------------------------
    // Fixed status bits: capabilities, reserved zeros, extended regs
    // ------------------------------------------------------------------
    localparam logic [15:0] STATUS_FIXED = 16'h7809;
    localparam int STS_AUTONEG_DONE = 5;
    localparam int STS_REMOTE_FAULT = 4;
    localparam int STS_LINK_UP      = 2;
    localparam int STS_JABBER       = 1;

    // ------------------------------------------------------------------
    // Management frame and timing constants
    // ------------------------------------------------------------------
    localparam logic [5:0]  PREAMBLE_ONES   = 6'h20;
    localparam logic [4:0]  ADDR_BITS_LAST  = 5'h09;
    localparam logic [4:0]  DATA_BITS_LAST  = 5'h0F;
    localparam int          CLK_HZ          = 25000000;
    localparam int          SOFT_RESET_MS   = 50;
    localparam int          SOFT_RESET_CYCLES = SOFT_RESET_MS * (CLK_HZ / 1000);

    // Operating mode handed to the PHY datapath
    typedef struct packed {
        logic loopBackEn;
        logic speed100;
        logic fullDuplex;
        logic powerDownReq;
        logic isolateDataIf;
        logic collisionTestEn;
    } phy_mode_s;

    // Line conditions reported by the PHY datapath
    typedef struct packed {
        logic linkUp;
        logic remoteFault;
        logic jabber;
        logic autonegComplete;
        logic autonegStarted;
        logic negSpeed100;
        logic negFullDuplex;
    } line_status_s;

endpackage : phy_mgmt_pkg

// ---- src/phy_mgmt_control_status_regs.sv ----
// Control and status registers of the PHY behind the MII management port
module phy_mgmt_control_status_regs #(
    parameter int RESET_CYCLES = phy_mgmt_pkg::SOFT_RESET_CYCLES
) (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    // Management serial port
    input  wire logic                       mdc,
    input  wire logic                       mdioIn,
    output logic                            mdioOut,
    output logic                            mdioOe_n,
    input  wire logic [4:0]                 phyAddr,
    // PHY datapath
    input  wire phy_mgmt_pkg::line_status_s lineStatus,
    output phy_mgmt_pkg::phy_mode_s         phyMode,
    output logic                            autonegRestart,
    output logic                            softResetActive
);
    import phy_mgmt_pkg::*;

    typedef enum {
        FR_PREAMBLE,
        FR_START,
        FR_OPCODE,
        FR_ADDR,
        FR_TURN,
        FR_DATA
    } frame_e;

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic        mdcS1;
    logic        mdcS2;
    logic        mdcS3;
    logic        mdcLevel;
    logic        mdioS1;
    logic        mdioS2;
    logic        mdioS3;
    logic        mdcRise;
    logic        bitIn;

    // Three stages for clock and data, edge taken once stages two and three agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mdcS1  <= 1'b1;
            mdcS2  <= 1'b1;
            mdcS3  <= 1'b1;
            mdioS1 <= 1'b1;
            mdioS2 <= 1'b1;
            mdioS3 <= 1'b1;
        end else begin
            mdcS1  <= mdc;
            mdcS2  <= mdcS1;
            mdcS3  <= mdcS2;
            mdioS1 <= mdioIn;
            mdioS2 <= mdioS1;
            mdioS3 <= mdioS2;
        end
    end

    // Accepted clock level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mdcLevel <= 1'b1;
        end else if (mdcS2 == mdcS3) begin
            mdcLevel <= mdcS3;
        end
    end

    assign mdcRise = mdcS2 & mdcS3 & ~mdcLevel;
    assign bitIn   = mdioS3;

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [15:0] ctrlReg;
    logic        resetBusy;
    logic [31:0] resetCount;
    logic        resetDone;
    logic        restartPending;
    logic        remoteFaultLatch;
    logic        linkLowLatch;
    logic        jabberLatch;
    logic        autonegEn;
    logic        effSpeed100;
    logic        effFullDuplex;
    logic [15:0] controlView;
    logic [15:0] statusView;
    logic [15:0] readMux;

    // ------------------------------------------------------------------
    // Frame receiver state
    // ------------------------------------------------------------------
    frame_e      state;
    logic [5:0]  preCount;
    logic [4:0]  bitCount;
    logic        opFirst;
    logic        opRead;
    logic [9:0]  addrShift;
    logic [4:0]  regAddr;
    logic        addrHit;
    logic [15:0] dataShift;
    logic [15:0] readShift;
    logic        wrStrobe;
    logic        statusRdPulse;
    logic [9:0]  addrFull;

    assign addrFull = {addrShift[8:0], bitIn};

    // Management frame decoder: preamble, start, opcode, address, turnaround, data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state         <= FR_PREAMBLE;
            preCount      <= 6'h00;
            bitCount      <= 5'h00;
            opFirst       <= 1'b0;
            opRead        <= 1'b0;
            addrShift     <= 10'h000;
            regAddr       <= 5'h00;
            addrHit       <= 1'b0;
            dataShift     <= 16'h0000;
            readShift     <= 16'h0000;
            wrStrobe      <= 1'b0;
            statusRdPulse <= 1'b0;
            mdioOut       <= 1'b1;
            mdioOe_n      <= 1'b1;
        end else begin
            wrStrobe      <= 1'b0;
            statusRdPulse <= 1'b0;
            if (mdcRise) begin
                case (state)
                    FR_PREAMBLE: begin
                        // Frames need a full preamble, none is accepted without
                        if (bitIn) begin
                            if (preCount != PREAMBLE_ONES) begin
                                preCount <= preCount + 6'h01;
                            end
                        end else if (preCount == PREAMBLE_ONES) begin
                            state <= FR_START;
                        end else begin
                            preCount <= 6'h00;
                        end
                    end
                    FR_START: begin
                        preCount <= 6'h00;
                        bitCount <= 5'h00;
                        state    <= bitIn ? FR_OPCODE : FR_PREAMBLE;
                    end
                    FR_OPCODE: begin
                        if (bitCount == 5'h00) begin
                            opFirst  <= bitIn;
                            bitCount <= 5'h01;
                        end else if (opFirst != bitIn) begin
                            opRead   <= opFirst;
                            bitCount <= 5'h00;
                            state    <= FR_ADDR;
                        end else begin
                            state <= FR_PREAMBLE;
                        end
                    end
                    FR_ADDR: begin
                        addrShift <= addrFull;
                        bitCount  <= bitCount + 5'h01;
                        if (bitCount == ADDR_BITS_LAST) begin
                            regAddr  <= addrFull[4:0];
                            addrHit  <= (addrFull[9:5] == phyAddr);
                            bitCount <= 5'h00;
                            state    <= FR_TURN;
                        end
                    end
                    FR_TURN: begin
                        bitCount <= bitCount + 5'h01;
                        if (bitCount == 5'h00) begin
                            // Snapshot read data; status read clears the latches
                            readShift <= readMux;
                            if (opRead && addrHit) begin
                                mdioOut       <= 1'b0;
                                mdioOe_n      <= 1'b0;
                                statusRdPulse <= (regAddr == REG_STATUS);
                            end
                        end else begin
                            bitCount <= 5'h00;
                            state    <= FR_DATA;
                            if (opRead && addrHit) begin
                                mdioOut   <= readShift[15];
                                readShift <= {readShift[14:0], 1'b0};
                            end
                        end
                    end
                    FR_DATA: begin
                        bitCount  <= bitCount + 5'h01;
                        dataShift <= {dataShift[14:0], bitIn};
                        if (opRead && addrHit) begin
                            mdioOut   <= readShift[15];
                            readShift <= {readShift[14:0], 1'b0};
                        end
                        if (bitCount == DATA_BITS_LAST) begin
                            mdioOut  <= 1'b1;
                            mdioOe_n <= 1'b1;
                            wrStrobe <= ~opRead & addrHit;
                            preCount <= 6'h00;
                            state    <= FR_PREAMBLE;
                        end
                    end
                    default: begin
                        state <= FR_PREAMBLE;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------------
    assign autonegEn = ctrlReg[CTL_AUTONEG_EN];

    // Control view: reset bit busy flag, restart bit gated by enable
    always_comb begin
        controlView                  = ctrlReg;
        controlView[CTL_SOFT_RESET]  = resetBusy;
        controlView[CTL_AUTONEG_RST] = restartPending & autonegEn;
    end

    // Status view: fixed capability bits plus live and latched flags
    always_comb begin
        statusView    = STATUS_FIXED;
        statusView[STS_AUTONEG_DONE] = lineStatus.autonegComplete & autonegEn;
        statusView[STS_REMOTE_FAULT] = remoteFaultLatch;
        statusView[STS_LINK_UP]      = lineStatus.linkUp & ~linkLowLatch;
        statusView[STS_JABBER]       = jabberLatch & ~effSpeed100;
    end

    // Offsets not held here read back as zero
    always_comb begin
        case (regAddr)
            REG_CONTROL: readMux = controlView;
            REG_STATUS:  readMux = statusView;
            default:     readMux = 16'h0000;
        endcase
    end

    // ------------------------------------------------------------------
    // Soft reset sequencer
    // ------------------------------------------------------------------
    // Busy from the write until the ready time has elapsed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            resetBusy  <= 1'b0;
            resetCount <= 32'h00000000;
            resetDone  <= 1'b0;
        end else begin
            resetDone <= 1'b0;
            if (resetBusy) begin
                if (resetCount == 32'(RESET_CYCLES - 1)) begin
                    resetBusy <= 1'b0;
                    resetDone <= 1'b1;
                end else begin
                    resetCount <= resetCount + 32'h00000001;
                end
            end else if (wrStrobe && regAddr == REG_CONTROL
                         && dataShift[CTL_SOFT_RESET]) begin
                resetBusy  <= 1'b1;
                resetCount <= 32'h00000000;
            end
        end
    end

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    // Writes land unless a soft reset is running or the write sets the reset bit; defaults return at its end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrlReg <= CONTROL_RESET;
        end else if (resetDone) begin
            ctrlReg <= CONTROL_RESET;
        end else if (wrStrobe && regAddr == REG_CONTROL && !resetBusy
                     && !dataShift[CTL_SOFT_RESET]) begin
            ctrlReg                  <= dataShift;
            ctrlReg[CTL_SOFT_RESET]  <= 1'b0;
            ctrlReg[CTL_AUTONEG_RST] <= 1'b0;
        end
    end

    // Negotiation restart request, held until the negotiator starts, negotiation is disabled or a soft reset ends
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            restartPending <= 1'b0;
        end else begin
            if (resetDone || !autonegEn || lineStatus.autonegStarted) begin
                restartPending <= 1'b0;
            end
            if (wrStrobe && regAddr == REG_CONTROL && !resetBusy
                && !dataShift[CTL_SOFT_RESET]
                && dataShift[CTL_AUTONEG_RST] && dataShift[CTL_AUTONEG_EN]) begin
                restartPending <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Latched status flags, set wins over a clearing read
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            remoteFaultLatch <= 1'b0;
            linkLowLatch     <= 1'b0;
            jabberLatch      <= 1'b0;
        end else if (resetDone) begin
            remoteFaultLatch <= 1'b0;
            linkLowLatch     <= 1'b0;
            jabberLatch      <= 1'b0;
        end else begin
            if (statusRdPulse) begin
                remoteFaultLatch <= 1'b0;
                linkLowLatch     <= 1'b0;
                jabberLatch      <= 1'b0;
            end
            if (lineStatus.remoteFault) begin
                remoteFaultLatch <= 1'b1;
            end
            if (!lineStatus.linkUp) begin
                linkLowLatch <= 1'b1;
            end
            if (lineStatus.jabber && !effSpeed100) begin
                jabberLatch <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Operating mode outputs
    // ------------------------------------------------------------------
    // Negotiated result overrides manual speed and duplex
    always_comb begin
        if (autonegEn) begin
            effSpeed100   = lineStatus.negSpeed100;
            effFullDuplex = lineStatus.negFullDuplex;
        end else begin
            effSpeed100   = ctrlReg[CTL_SPEED];
            effFullDuplex = ctrlReg[CTL_DUPLEX];
        end
    end

    // Registered mode to the datapath; management port never gated by it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phyMode         <= '0;
            autonegRestart  <= 1'b0;
            softResetActive <= 1'b0;
        end else begin
            phyMode.loopBackEn      <= ctrlReg[CTL_LOOP_BACK];
            phyMode.speed100        <= effSpeed100;
            phyMode.fullDuplex      <= effFullDuplex;
            phyMode.powerDownReq    <= ctrlReg[CTL_POWER_DOWN];
            phyMode.isolateDataIf   <= ctrlReg[CTL_ISOLATE];
            phyMode.collisionTestEn <= ctrlReg[CTL_COL_TEST];
            autonegRestart          <= restartPending & autonegEn;
            softResetActive         <= resetBusy;
        end
    end

endmodule : phy_mgmt_control_status_regs

// ---- verification/phy_mgmt_regs_checker.sv ----
// Assertion checker for the PHY management register bank
module phy_mgmt_regs_checker #(
    parameter int RESET_CYCLES = 20
) (
    // Clock and reset
    input wire logic                       clk,
    input wire logic                       rst_n,
    // Management port
    input wire logic                       mdc,
    input wire logic                       mdioIn,
    input wire logic                       mdioOut,
    input wire logic                       mdioOe_n,
    input wire logic [4:0]                 phyAddr,
    // Datapath side
    input wire phy_mgmt_pkg::line_status_s lineStatus,
    input wire phy_mgmt_pkg::phy_mode_s    phyMode,
    input wire logic                       autonegRestart,
    input wire logic                       softResetActive
);
    import phy_mgmt_pkg::*;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------------
    // Soft reset length counter
    // ------------------------------------------------------------------
    int resetLen;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            resetLen <= 0;
        end else begin
            resetLen <= softResetActive ? resetLen + 1 : 0;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    soft_len_a: assert property ($fell(softResetActive) |-> resetLen >= RESET_CYCLES)
        else $error("soft reset ended early");
    soft_bound_a: assert property (softResetActive |-> resetLen <= RESET_CYCLES)
        else $error("soft reset lasted too long");
    reset_defaults_a: assert property ($fell(softResetActive) |-> ##[0:2]
        (phyMode.isolateDataIf && !phyMode.loopBackEn && !phyMode.powerDownReq))
        else $error("mode not restored after soft reset");
    reset_hold_a: assert property (softResetActive ##1 softResetActive |->
        $stable({phyMode.loopBackEn, phyMode.powerDownReq, phyMode.isolateDataIf}))
        else $error("mode changed during soft reset");
    reset_start_a: assert property ($rose(softResetActive) |-> mdioOe_n)
        else $error("soft reset began inside a read");
    ta_zero_a: assert property ($fell(mdioOe_n) |-> !mdioOut)
        else $error("turnaround bit not zero");
    idle_high_a: assert property (mdioOe_n |-> mdioOut)
        else $error("idle data output not high");
    bit_hold_a: assert property (!mdioOe_n && $changed(mdioOut) |=> $stable(mdioOut) [*6])
        else $error("read bit did not stand");
    restart_clr_a: assert property (autonegRestart && lineStatus.autonegStarted
        |-> ##[1:2] !autonegRestart)
        else $error("restart request not cleared");

    // Main scenarios reached
    cover property ($fell(softResetActive));
    cover property ($fell(mdioOe_n));
    cover property ($fell(autonegRestart));

endmodule : phy_mgmt_regs_checker

bind phy_mgmt_control_status_regs phy_mgmt_regs_checker #(.RESET_CYCLES(RESET_CYCLES)) CHK (
    .clk(clk), .rst_n(rst_n), .mdc(mdc), .mdioIn(mdioIn), .mdioOut(mdioOut),
    .mdioOe_n(mdioOe_n), .phyAddr(phyAddr), .lineStatus(lineStatus), .phyMode(phyMode),
    .autonegRestart(autonegRestart), .softResetActive(softResetActive)
);

// ---- verification/mdio_host_model.sv ----
// Behavioural station management host making MDC and management frames
module mdio_host_model (
    // Clock
    input wire logic clk,
    // Management wire
    input wire logic wireBit,
    output logic     mdc,
    output logic     hostBit
);
    timeunit 1ns;
    timeprecision 1ns;

    logic sample;

    // Clock and line start high; between frames the clock stands high and the line keeps the last bit driven
    initial begin
        mdc = 1'b1;
        hostBit = 1'b1;
    end

    // One management bit: eight clocks, wire taken at the rising edge
    task automatic tick(input logic b);
        @(posedge clk);
        mdc <= 1'b0;
        hostBit <= b;
        repeat (4) @(posedge clk);
        sample <= wireBit;
        mdc <= 1'b1;
        repeat (3) @(posedge clk);
    endtask : tick

    // Whole frame; a read returns turnaround zero above the data word
    task automatic frame(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [16:0] got);
        logic [13:0] head;
        head = {2'b01, rd ? 2'b10 : 2'b01, pa, ra};
        got = '0;
        repeat (32) tick(1'b1);
        for (int i = 13; i >= 0; i--) tick(head[i]);
        if (rd) begin
            tick(1'b1); // First turnaround bit, line released
            for (int i = 0; i < 17; i++) begin
                tick(1'b1);
                got = {got[15:0], sample};
            end
        end else begin
            tick(1'b1);
            tick(1'b0);
            for (int i = 15; i >= 0; i--) tick(wd[i]);
        end
    endtask : frame

endmodule : mdio_host_model

// ---- verification/tb_phy_mgmt_control_status_regs.sv ----
// Self-checking bench for the PHY management register bank
module tb_phy_mgmt_control_status_regs;
    timeunit 1ns;
    timeprecision 1ns;
    import phy_mgmt_pkg::*;

    localparam int RST_LEN = 20;
    logic         clk        = 1'b0;
    logic         rst_n      = 1'b0;
    logic         mdc;
    logic         hostBit;
    logic         mdioOut;
    logic         mdioOe_n;
    line_status_s lineStatus = 7'h40;
    phy_mode_s    phyMode;
    logic         autonegRestart;
    logic         softResetActive;
    logic [16:0]  got;
    logic [15:0]  vals [3]   = '{16'h4100, 16'h2880, 16'h0200};
    logic [4:0]   others [3] = '{5'h02, 5'h10, 5'h13};
    int           failCount  = 0;
    int           nChecks    = 0;
    wire logic    mdioIn     = mdioOe_n ? hostBit : mdioOut;

    always #20 clk = ~clk;

    phy_mgmt_control_status_regs #(.RESET_CYCLES(RST_LEN)) DUT (
        .clk(clk), .rst_n(rst_n), .mdc(mdc), .mdioIn(mdioIn), .mdioOut(mdioOut),
        .mdioOe_n(mdioOe_n), .phyAddr(5'h05), .lineStatus(lineStatus), .phyMode(phyMode),
        .autonegRestart(autonegRestart), .softResetActive(softResetActive)
    );

    mdio_host_model HOST (.clk(clk), .wireBit(mdioIn), .mdc(mdc), .hostBit(hostBit));

    // ------------------------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
        nChecks++;
        if (seen !== exp) begin
            failCount++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        HOST.frame(1'b0, 5'h05, ra, d, got);
        repeat (10) @(posedge clk);
    endtask : wr

    task automatic rd(input logic [4:0] ra, input logic [15:0] exp, input string what);
        HOST.frame(1'b1, 5'h05, ra, 16'h0000, got);
        check(what, got, {1'b0, exp});
    endtask : rd

    task automatic mode(input logic [15:0] v);
        check("phyMode", phyMode, {v[14], v[13], v[8], v[11], v[10], v[7]});
    endtask : mode

    task automatic setLine(input line_status_s s);
        @(posedge clk);
        lineStatus <= s;
        repeat (4) @(posedge clk);
    endtask : setLine

    task automatic stopTest();
        if (failCount == 0 && nChecks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stopTest

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        check("phyMode", phyMode, 6'h02);
        rd(5'h00, 16'h3400, "control");
        HOST.frame(1'b1, 5'h05, 5'h01, 16'h0000, got);
        rd(5'h01, 16'h780D, "status");
        setLine(7'h20);
        setLine(7'h40);
        rd(5'h01, 16'h7819, "status");
        rd(5'h01, 16'h780D, "status");
        setLine(7'h50);
        setLine(7'h40);
        rd(5'h01, 16'h780F, "status");
        setLine(7'h52);
        setLine(7'h42);
        rd(5'h01, 16'h780D, "status");
        setLine(7'h4B);
        rd(5'h01, 16'h782D, "status");
        check("phyMode", phyMode, 6'h1A);
        // Manual modes with negotiation off
        foreach (vals[i]) begin
            wr(5'h00, vals[i]);
            mode(vals[i]);
            rd(5'h00, vals[i] & 16'hFDFF, "control");
        end
        wr(5'h01, 16'h0000);
        rd(5'h01, 16'h780D, "status");
        // Negotiation restart request
        wr(5'h00, 16'h1200);
        check("restart", autonegRestart, 1'b1);
        rd(5'h00, 16'h1200, "control");
        setLine(7'h4F);
        check("restart", autonegRestart, 1'b0);
        rd(5'h00, 16'h1000, "control");
        setLine(7'h4B);
        wr(5'h00, 16'h1000);
        check("restart", autonegRestart, 1'b0);
        // Unimplemented offsets and a foreign address
        foreach (others[i]) rd(others[i], 16'h0000, "other register");
        HOST.frame(1'b1, 5'h06, 5'h00, 16'h0000, got);
        check("foreign read", got, 17'h1FFFF);
        // Soft reset
        wr(5'h00, 16'h8000);
        check("softReset", softResetActive, 1'b1);
        repeat (RST_LEN + 10) @(posedge clk);
        check("softReset", softResetActive, 1'b0);
        check("phyMode", phyMode, 6'h1A);
        rd(5'h00, 16'h3400, "control");
        stopTest();
    end

    // Cuts a hang short
    initial begin
        repeat (60000) @(posedge clk);
        failCount++;
        stopTest();
    end

endmodule : tb_phy_mgmt_control_status_regs
